// file: src/dccu_top.v
// dual capture/compare unit: two register sets sharing one 16-bit timer.
// assumes the timer, its count strobe and its overflow pulse come from
// outside, all synchronous to i_ref_clk (instruction clock).
`default_nettype none
`include "dccu_consts.vh"

module dccu_top #(
  parameter TW = 16
) (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [TW-1:0] i_timer_count,
  input wire i_timer_tick,
  input wire i_timer_ovf,
  input wire i_event_pin_in,
  input wire i_event_port_out,
  input wire i_event_port_oe,
  input wire i_adc_en,
  output reg [1:0] o_cmp_out,
  output reg [1:0] o_cmp_drive,
  output reg o_adc_start,
  output reg o_irq
);

  // mode decoding used by both sets
  function is_capture;
    input [3:0] m;
    begin
      is_capture = (m[3:2] == 2'b01);
    end
  endfunction

  function is_pin_compare;
    input [3:0] m;
    begin
      is_pin_compare = (m == `DCCU_M_CMP_SET) || (m == `DCCU_M_CMP_CLR) ||
                       (m == `DCCU_M_CMP_TGL);
    end
  endfunction

  function is_flag_compare;
    input [3:0] m;
    begin
      // reserved code does nothing
      is_flag_compare = m[3] && (m != `DCCU_M_RSVD);
    end
  endfunction

  reg [7:0] ctrl_r;
  reg [7:0] flag_r;
  reg [7:0] mask_r;
  reg [7:0] flag_nxt;
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_prev_r;
  wire pin_level;
  wire pin_rise;
  wire pin_fall;
  wire [1:0] set_evt;
  wire [1:0] set_special;
  wire [31:0] val_flat;

  // an output-configured pin still feeds the edge detector
  assign pin_level = i_event_port_oe ? i_event_port_out
                                     : i_event_pin_in;

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_level;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r && !pin_prev_r;
  assign pin_fall = !pin_s2_r && pin_prev_r;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_set
      wire [3:0] mode;
      wire cap_on;
      wire cap_evt;
      wire match;
      wire cmp_evt;
      wire [3:0] a_lo;
      wire [3:0] a_hi;
      reg [TW-1:0] val_r;
      reg [3:0] cnt_r;
      reg cmp_r;
      reg [3:0] prev_mode_r;

      assign mode = ctrl_r[4*g +: 4];
      assign a_lo = (g == 0) ? `DCCU_A_VAL1_LO : `DCCU_A_VAL2_LO;
      assign a_hi = (g == 0) ? `DCCU_A_VAL1_HI : `DCCU_A_VAL2_HI;
      assign cap_on = is_capture(mode);
      assign cap_evt = cap_on && (
          ((mode == `DCCU_M_CAP_FALL) && pin_fall) ||
          ((mode == `DCCU_M_CAP_RISE) && pin_rise) ||
          ((mode == `DCCU_M_CAP_RISE4) && pin_rise &&
           (cnt_r[1:0] == `DCCU_PRE4_LAST)) ||
          ((mode == `DCCU_M_CAP_RISE16) && pin_rise &&
           (cnt_r == `DCCU_PRE16_LAST)));
      // compare is evaluated once per timer count
      assign match = i_timer_tick && (i_timer_count == val_r);
      assign cmp_evt = is_flag_compare(mode) && match;
      assign set_evt[g] = cap_evt || cmp_evt;
      assign set_special[g] = (mode == `DCCU_M_CMP_SPECIAL) && match;
      assign val_flat[16*g +: 16] = val_r;

      // prescaler: changing between prescale codes keeps the count
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_r <= 4'h0;
        end else if (!cap_on) begin
          cnt_r <= 4'h0;
        end else if (pin_rise && mode[1]) begin
          cnt_r <= cnt_r + 4'h1;
        end
      end

      // capture beats a same-cycle software write
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          val_r <= `DCCU_VAL_RST;
        end else if (cap_evt) begin
          val_r <= i_timer_count;
        end else if (i_wr && (i_addr == a_lo)) begin
          val_r[7:0] <= i_wdata;
        end else if (i_wr && (i_addr == a_hi)) begin
          val_r[15:8] <= i_wdata;
        end
      end

      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cmp_r <= 1'b0;
          prev_mode_r <= 4'h0;
        end else begin
          prev_mode_r <= mode;
          if (mode[3:2] == 2'b00) begin
            cmp_r <= 1'b0;
          end else if ((mode == `DCCU_M_CMP_CLR) && (prev_mode_r != mode)) begin
            // clear-on-match starts from its idle high level
            cmp_r <= 1'b1;
          end else if (match && is_pin_compare(mode)) begin
            case (mode)
              `DCCU_M_CMP_SET: cmp_r <= 1'b1;
              `DCCU_M_CMP_CLR: cmp_r <= 1'b0;
              default: cmp_r <= ~cmp_r;
            endcase
          end
        end
      end

      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          o_cmp_out[g] <= 1'b0;
          o_cmp_drive[g] <= 1'b0;
        end else begin
          o_cmp_out[g] <= cmp_r;
          // soft and special modes leave the pin as plain i/o
          o_cmp_drive[g] <= is_pin_compare(mode);
        end
      end
    end
  endgenerate

  // set wins over a same-cycle write-one clear
  always @* begin
    flag_nxt = flag_r;
    if (i_wr && (i_addr == `DCCU_A_FLAG)) begin
      flag_nxt = flag_r & ~i_wdata;
    end
    // special event never touches the overflow bit
    flag_nxt[`DCCU_FLAG_TOVF] = flag_nxt[`DCCU_FLAG_TOVF] | i_timer_ovf;
    flag_nxt[`DCCU_FLAG_SET1] = flag_nxt[`DCCU_FLAG_SET1] | set_evt[0];
    flag_nxt[`DCCU_FLAG_SET2] = flag_nxt[`DCCU_FLAG_SET2] | set_evt[1];
  end

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `DCCU_CTRL_RST;
      flag_r <= `DCCU_FLAG_RST;
      mask_r <= `DCCU_MASK_RST;
      o_irq <= 1'b0;
      o_adc_start <= 1'b0;
    end else begin
      if (i_wr && (i_addr == `DCCU_A_CTRL)) begin
        ctrl_r <= i_wdata;
      end
      if (i_wr && (i_addr == `DCCU_A_MASK)) begin
        mask_r <= i_wdata;
      end
      flag_r <= flag_nxt;
      o_irq <= |(flag_nxt & mask_r);
      o_adc_start <= (|set_special) && i_adc_en;
    end
  end

  // read data stands one cycle after the read strobe only
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= `DCCU_RDATA_RST;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == `DCCU_A_CTRL) begin
      o_rdata <= ctrl_r;
    end else if (i_addr == `DCCU_A_FLAG) begin
      o_rdata <= flag_r;
    end else if (i_addr == `DCCU_A_MASK) begin
      o_rdata <= mask_r;
    end else if (i_addr == `DCCU_A_VAL1_LO) begin
      o_rdata <= val_flat[7:0];
    end else if (i_addr == `DCCU_A_VAL1_HI) begin
      o_rdata <= val_flat[15:8];
    end else if (i_addr == `DCCU_A_VAL2_LO) begin
      o_rdata <= val_flat[23:16];
    end else if (i_addr == `DCCU_A_VAL2_HI) begin
      o_rdata <= val_flat[31:24];
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // dccu_top
`default_nettype wire

// file: shared/dccu_consts.vh
// constants of the dual capture/compare unit: register offsets, flag
// bit positions, mode codes and reset values.
// assumes an 8-bit register port with a 4-bit word address.
`ifndef DCCU_CONSTS_VH
`define DCCU_CONSTS_VH

// register offsets (word address on i_addr)
`define DCCU_ADDR_W 4
`define DCCU_DATA_W 8
`define DCCU_A_CTRL 4'h0
`define DCCU_A_FLAG 4'h1
`define DCCU_A_MASK 4'h2
`define DCCU_A_VAL1_LO 4'h3
`define DCCU_A_VAL1_HI 4'h4
`define DCCU_A_VAL2_LO 4'h5
`define DCCU_A_VAL2_HI 4'h6

// peripheral_flag_reg bit positions
`define DCCU_FLAG_TOVF 0
`define DCCU_FLAG_SET1 2
`define DCCU_FLAG_SET2 3

// reset values
`define DCCU_CTRL_RST 8'h00
`define DCCU_FLAG_RST 8'h00
`define DCCU_MASK_RST 8'h00
`define DCCU_VAL_RST 16'h0000
`define DCCU_RDATA_RST 8'h00

// set_mode_field codes
`define DCCU_MODE_W 4
`define DCCU_M_CAP_FALL 4'h4
`define DCCU_M_CAP_RISE 4'h5
`define DCCU_M_CAP_RISE4 4'h6
`define DCCU_M_CAP_RISE16 4'h7
`define DCCU_M_CMP_SET 4'h8
`define DCCU_M_CMP_CLR 4'h9
`define DCCU_M_CMP_TGL 4'hA
`define DCCU_M_RSVD 4'hB
`define DCCU_M_CMP_SPECIAL 4'hF

// prescaler terminal counts
`define DCCU_PRE4_LAST 2'h3
`define DCCU_PRE16_LAST 4'hF

`endif

// file: dv/dccu_asserts.sv
// port checker for the dual capture/compare unit.
// assumes control is written only by i_wr at address 0.
`default_nettype none
module dccu_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_timer_tick,
  input wire logic i_adc_en,
  input wire logic [1:0] o_cmp_out,
  input wire logic [1:0] o_cmp_drive,
  input wire logic o_adc_start
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl_r;
  wire cw = i_wr && i_addr == 4'h0;
  // shadow of the control byte, so mode can be seen from the ports
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) ctl_r <= 8'h00;
    else if (cw) ctl_r <= i_wdata;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data seen outside read cycle");
  a_adc_single: assert property (o_adc_start |=> !o_adc_start)
    else $error("trigger longer than one cycle");
  a_adc_cause: assert property (o_adc_start |->
    $past(i_adc_en && i_timer_tick) &&
    $past(ctl_r[3:0] == 4'hF || ctl_r[7:4] == 4'hF))
    else $error("trigger without special mode match");
  a_off_latch: assert property (cw && i_wdata[3:2] == 2'b00 |->
    ##3 !o_cmp_out[0] && !o_cmp_drive[0])
    else $error("latch not reset when set is off");
  a_clr_default: assert property (cw && i_wdata[3:0] == 4'h9 &&
    ctl_r[3:0] != 4'h9 |-> ##3 o_cmp_out[0])
    else $error("clear-on-match latch not preset");
  a_cmp_cause: assert property ($changed(o_cmp_out) |->
    $past(i_timer_tick, 2) || $past(cw, 3))
    else $error("compare latch moved without cause");
  a_drive_cause: assert property ($changed(o_cmp_drive) |->
    $past(cw) || $past(cw, 2))
    else $error("pin drive moved without control write");
  a_soft_pin: assert property ((ctl_r[3:2] == 2'b11) [*3] |->
    !o_cmp_drive[0])
    else $error("pin driven in interrupt-only mode");
endmodule // dccu_asserts
bind dccu_top dccu_asserts dccu_asserts_i (.i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_tick(i_timer_tick),
  .i_adc_en(i_adc_en), .o_cmp_out(o_cmp_out),
  .o_cmp_drive(o_cmp_drive), .o_adc_start(o_adc_start));
`default_nettype wire

// file: dv/dccu_pin_model.sv
// event pin source: one pulse of four cycles per request.
// assumes i_go is a one-cycle request; idle level is low (pull-down).
`default_nettype none
module dccu_pin_model (
  input wire logic i_ref_clk,
  input wire logic i_go,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold_r = 3'h0;
  // long enough that the two-flop sync sees both levels
  always @(posedge i_ref_clk) begin
    if (i_go) hold_r <= 3'h4;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
  end
  assign o_pin = hold_r != 3'h0;
endmodule // dccu_pin_model
`default_nettype wire

// file: dv/dccu_top_tb.sv
// self-checking bench of the dual capture/compare unit.
// assumes the pin model above and the bound checker.
`default_nettype none
module dccu_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, tick = 0, ovf = 0, go = 0;
  logic pout = 0, poe = 0, aen = 1, run = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [15:0] cnt = 16'h0000;
  wire [7:0] rdata;
  wire [1:0] cout, cdrv;
  wire adcs, irq, pin;
  int miscompares = 0, checks_done = 0, nadc = 0;
  dccu_top dccu_top_i (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_timer_count(cnt), .i_timer_tick(tick), .i_timer_ovf(ovf),
    .i_event_pin_in(pin), .i_event_port_out(pout),
    .i_event_port_oe(poe), .i_adc_en(aen), .o_cmp_out(cout),
    .o_cmp_drive(cdrv), .o_adc_start(adcs), .o_irq(irq));
  dccu_pin_model dccu_pin_model_i (.i_ref_clk(clk), .i_go(go), .o_pin(pin));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    if (run) cnt <= cnt + 16'h0001;
    tick <= run;
    if (adcs === 1'b1) nadc <= nadc + 1;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 0;
  endtask
  task rc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 chk(n, e, rdata);
  endtask
  task pls(input int n);
    repeat (n) begin
      @(posedge clk) go <= 1;
      @(posedge clk) go <= 0;
      repeat (3) @(posedge clk);
      // timer moves between rise and fall, telling the edges apart
      cnt <= cnt + 16'h0100;
      repeat (6) @(posedge clk);
    end
  endtask
  task cap(input logic [7:0] c, input int n, input logic [7:0] f,
      input logic [3:0] va, input logic [7:0] h);
    wr8(4'h0, 8'h00);
    wr8(4'h0, c);
    wr8(4'h1, 8'hFF);
    cnt <= 16'h005A;
    if (c[1]) begin
      pls(n - 1);
      rc("early flag", 4'h1, 8'h00);
    end else pls(n - 1);
    pls(1);
    rc("flag", 4'h1, f);
    rc("cap lo", va, 8'h5A);
    rc("cap hi", va + 4'h1, h);
  endtask
  task cmp(input logic [7:0] c, input bit s, input logic [1:0] eo,
      input logic [1:0] ed, input int ea, input logic [7:0] ef);
    wr8(4'h0, 8'h00);
    wr8(s ? 4'h5 : 4'h3, 8'h40);
    wr8(s ? 4'h6 : 4'h4, 8'h00);
    wr8(4'h0, c);
    wr8(4'h1, 8'hFF);
    @(posedge clk) {cnt, nadc, run} <= {16'h0000, 32'd0, 1'b1};
    repeat (100) @(posedge clk);
    run <= 0;
    repeat (4) @(posedge clk);
    chk("cmp out", eo, cout);
    chk("cmp drive", ed, cdrv);
    chk("adc starts", ea, nadc);
    rc("cmp flag", 4'h1, ef);
  endtask
  task ci(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("irq", e, irq);
  endtask
  task end_sim;
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200us miscompares++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    rc("ctrl", 4'h0, 8'h00);
    rc("mask", 4'h2, 8'h00);
    rc("unmapped", 4'hF, 8'h00);
    cap(8'h05, 1, 8'h04, 4'h3, 8'h00);
    cap(8'h05, 2, 8'h04, 4'h3, 8'h01);
    cap(8'h40, 1, 8'h08, 4'h5, 8'h01);
    cap(8'h06, 4, 8'h04, 4'h3, 8'h03);
    cap(8'h07, 16, 8'h04, 4'h3, 8'h0F);
    wr8(4'h0, 8'h00);
    wr8(4'h0, 8'h06);
    pls(2);
    wr8(4'h0, 8'h07);
    wr8(4'h1, 8'hFF);
    pls(13);
    rc("kept prescale", 4'h1, 8'h00);
    pls(1);
    rc("kept prescale", 4'h1, 8'h04);
    wr8(4'h0, 8'h05);
    wr8(4'h1, 8'hFF);
    {poe, pout} <= 2'b11;
    ci(1'b0);
    rc("port capture", 4'h1, 8'h04);
    {poe, pout} <= 2'b00;
    cmp(8'h08, 0, 2'b01, 2'b01, 0, 8'h04);
    cmp(8'h09, 0, 2'b00, 2'b01, 0, 8'h04);
    cmp(8'h0A, 0, 2'b01, 2'b01, 0, 8'h04);
    cmp(8'h0B, 0, 2'b00, 2'b00, 0, 8'h00);
    cmp(8'h0C, 0, 2'b00, 2'b00, 0, 8'h04);
    cmp(8'hA0, 1, 2'b10, 2'b10, 0, 8'h08);
    cmp(8'hF0, 1, 2'b00, 2'b00, 1, 8'h08);
    aen <= 0;
    cmp(8'hF0, 1, 2'b00, 2'b00, 0, 8'h08);
    aen <= 1;
    wr8(4'h0, 8'h00);
    wr8(4'h2, 8'h01);
    @(posedge clk) ovf <= 1;
    @(posedge clk) ovf <= 0;
    ci(1'b1);
    rc("ovf flag", 4'h1, 8'h09);
    wr8(4'h2, 8'h00);
    ci(1'b0);
    wr8(4'h2, 8'h01);
    ci(1'b1);
    wr8(4'h1, 8'h01);
    ci(1'b0);
    rc("cleared", 4'h1, 8'h08);
    end_sim;
  end
endmodule // dccu_top_tb
`default_nettype wire
